//--- design/fes_ctrl.v
// host controller for a parallel NOR flash: erase, suspend/resume, auto-select
// assumes an APB master on the register side and the flash wired to the pins
`timescale 1ns/1ps
`include "fes_defs.vh"

module fes_ctrl (
  input  wire        clk,            // system clock
  input  wire        rstn,           // async reset, active low
  input  wire        psel,           // apb select
  input  wire        penable,        // apb access phase
  input  wire        pwrite,         // apb direction
  input  wire [7:0]  paddr,          // apb byte address
  input  wire [31:0] pwdata,         // apb write data
  output reg  [31:0] prdata,         // apb read data
  output wire        pready,         // apb ready
  output wire        pslverr,        // apb error
  output wire [19:0] flash_addr,     // flash address pins
  output wire [15:0] flash_dq_o,     // flash data out
  output wire        flash_dq_oe,    // flash data driven
  input  wire [15:0] flash_dq_i,     // flash data in
  output wire        flash_ce_n,     // flash chip enable
  output wire        flash_oe_n,     // flash output enable
  output wire        flash_we_n,     // flash write enable
  output wire        flash_reset_n,  // flash hardware reset
  output wire        id_hv_en,       // high voltage onto identification_hv_pin
  input  wire        ready_busy_n    // flash ready/busy, low busy
);

  // host view of the device mode
  localparam [2:0] M_READ = 3'd0, M_ASEL = 3'd1, M_ERS = 3'd2, M_SUSP = 3'd3, M_SASEL = 3'd4;
  // sequencer states
  localparam [2:0] S_IDLE = 3'd0, S_STEP = 3'd1, S_WAIT = 3'd2, S_PA = 3'd3, S_PB = 3'd4;
  localparam integer GAP_N = `FES_GAP_TICKS, SMAX_N = `FES_SUSP_MAX;
  localparam [11:0] GAP = GAP_N[11:0];
  localparam [10:0] SMAX = SMAX_N[10:0];

  reg  [3:0]  cmd_q;
  reg  [19:0] addr_q;
  reg  [15:0] wdata_q, rdata_q, first_q, stat_q;
  reg  [2:0]  mode_q, st_q, step_q;
  reg  [1:0]  ctrl_q;
  reg         refused_q, fail_q, issued_q, abort_q, inflight_q;
  reg  [11:0] gap_q;
  reg  [10:0] scnt_q;
  wire        tick, cyc_done;
  wire [15:0] cyc_rdata;
  reg         cyc_start;
  reg  [37:0] stepw;
  reg         accept;
  wire        busy = (st_q != S_IDLE);
  wire        wr_en = psel & penable & pwrite;
  wire        cmd_wr = wr_en & (paddr == `FES_REG_CMD);
  wire        hv_on = ctrl_q[1];
  wire        toggling = (first_q[`FES_B_TOGGLE] != cyc_rdata[`FES_B_TOGGLE]);
  wire        mapped = (paddr == `FES_REG_CMD) | (paddr == `FES_REG_ADDR) | (paddr == `FES_REG_WDATA) |
                       (paddr == `FES_REG_STATUS) | (paddr == `FES_REG_RDATA) | (paddr == `FES_REG_CTRL) |
                       (paddr == `FES_REG_SCOUNT);

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign flash_reset_n = ~ctrl_q[0];
  assign id_hv_en = hv_on;

  ////////////////////////////////////////////////////////////////////////
  // step table: {last, read, address, data} for each command and step
  always @* begin
    stepw = {1'b1, 1'b1, addr_q, 16'h0000};
    case (cmd_q)
      `FES_C_CHIP_ERASE, `FES_C_SECT_ERASE, `FES_C_PROGRAM, `FES_C_AUTOSEL: begin
        case (step_q)
          3'd0, 3'd3: stepw = {2'b00, `FES_UNLOCK_A1, `FES_D_UNLOCK1};
          3'd1, 3'd4: stepw = {2'b00, `FES_UNLOCK_A2, `FES_D_UNLOCK2};
          3'd2: begin
            if (cmd_q == `FES_C_AUTOSEL) begin
              stepw = {2'b10, `FES_UNLOCK_A1, `FES_D_AUTOSEL};
            end else if (cmd_q == `FES_C_PROGRAM) begin
              stepw = {2'b00, `FES_UNLOCK_A1, `FES_D_PROGRAM};
            end else begin
              stepw = {2'b00, `FES_UNLOCK_A1, `FES_D_CONFIG};
            end
          end
          default: begin
            if (cmd_q == `FES_C_PROGRAM) begin
              stepw = {2'b10, addr_q, wdata_q};
            end else if (cmd_q == `FES_C_CHIP_ERASE) begin
              stepw = {2'b10, `FES_UNLOCK_A1, `FES_D_CHIP_ERASE};
            end else begin
              stepw = {2'b10, addr_q, `FES_D_SECT_ERASE};
            end
          end
        endcase
      end
      `FES_C_SUSPEND:    stepw = {2'b10, addr_q, `FES_D_SUSPEND};
      `FES_C_RESUME:     stepw = {2'b10, addr_q, `FES_D_RESUME};
      `FES_C_RESET:      stepw = {2'b10, addr_q, `FES_D_RESET};
      `FES_C_READ_MID:   stepw = {2'b11, addr_q[19:2], 2'b00, 16'h0000};
      `FES_C_READ_DID:   stepw = {2'b11, addr_q[19:2], 2'b01, 16'h0000};
      `FES_C_PROT_VFY:   stepw = {2'b11, addr_q[19:12], `FES_PROT_LOW, 16'h0000};
      default:           stepw = {2'b11, addr_q, 16'h0000};
    endcase
    if (abort_q) begin
      stepw = {2'b10, addr_q, `FES_D_RESET};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // which commands the device takes in the present mode
  always @* begin
    accept = 1'b0;
    case (pwdata[3:0])
      `FES_C_CHIP_ERASE, `FES_C_SECT_ERASE: accept = (mode_q == M_READ);
      `FES_C_SUSPEND:  accept = (mode_q == M_ERS) & (gap_q == 12'h000) & (scnt_q < SMAX);
      `FES_C_RESUME:   accept = (mode_q == M_SUSP);
      `FES_C_AUTOSEL:  accept = (mode_q == M_READ) | (mode_q == M_SUSP);
      `FES_C_PROGRAM, `FES_C_READ: accept = (mode_q == M_READ) | (mode_q == M_SUSP);
      `FES_C_RESET:    accept = (mode_q != M_ERS);
      `FES_C_READ_MID, `FES_C_READ_DID, `FES_C_PROT_VFY:
        accept = (mode_q == M_ASEL) | (mode_q == M_SASEL) | hv_on;
      `FES_C_WAIT_ERASE: accept = (mode_q == M_ERS);
      default:         accept = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // apb writes to the plain registers; read data latched in the setup cycle
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_q <= 20'h00000;
      wdata_q <= 16'h0000;
      ctrl_q <= 2'b00;
      prdata <= 32'h00000000;
    end else begin
      if (wr_en & (paddr == `FES_REG_ADDR)) addr_q <= pwdata[19:0];
      if (wr_en & (paddr == `FES_REG_WDATA)) wdata_q <= pwdata[15:0];
      if (wr_en & (paddr == `FES_REG_CTRL)) ctrl_q <= pwdata[1:0];
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          `FES_REG_CMD:    prdata <= {28'h0000000, cmd_q};
          `FES_REG_ADDR:   prdata <= {12'h000, addr_q};
          `FES_REG_WDATA:  prdata <= {16'h0000, wdata_q};
          `FES_REG_STATUS: prdata <= {stat_q, 8'h00, ready_busy_n, rdata_q[0], mode_q, fail_q, refused_q, busy};
          `FES_REG_RDATA:  prdata <= {16'h0000, rdata_q};
          `FES_REG_CTRL:   prdata <= {30'h00000000, ctrl_q};
          `FES_REG_SCOUNT: prdata <= {21'h000000, scnt_q};
          default:         prdata <= 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer: issue the steps, then poll toggle bit for the busy phases
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_q <= 4'h0;
      st_q <= S_IDLE;
      step_q <= 3'd0;
      mode_q <= M_READ;
      refused_q <= 1'b0;
      fail_q <= 1'b0;
      issued_q <= 1'b0;
      abort_q <= 1'b0;
      inflight_q <= 1'b0;
      cyc_start <= 1'b0;
      rdata_q <= 16'h0000;
      first_q <= 16'h0000;
      stat_q <= 16'h0000;
      gap_q <= 12'h000;
      scnt_q <= 11'h000;
    end else begin
      cyc_start <= 1'b0;
      // a cycle cut off by the reset pin still ends; its done must not count
      if (cyc_start) inflight_q <= 1'b1;
      else if (cyc_done) inflight_q <= 1'b0;
      if (tick & (gap_q != 12'h000)) gap_q <= gap_q - 12'h001;
      if (ctrl_q[0]) begin
        // hardware reset pin held: any erase is gone, device back in read mode
        st_q <= S_IDLE;
        mode_q <= M_READ;
        abort_q <= 1'b0;
        gap_q <= 12'h000;
        scnt_q <= 11'h000;
      end else begin
        case (st_q)
          S_IDLE: begin
            if (cmd_wr) begin
              // refusal is sticky until the next accepted command
              refused_q <= ~accept;
              if (accept) begin
                cmd_q <= pwdata[3:0];
                fail_q <= 1'b0;
                step_q <= 3'd0;
                issued_q <= 1'b0;
                st_q <= (pwdata[3:0] == `FES_C_WAIT_ERASE) ? S_PA : S_STEP;
              end
            end
          end
          S_STEP: begin
            if (!issued_q & !inflight_q) begin
              cyc_start <= 1'b1;
              issued_q <= 1'b1;
            end else if (issued_q & cyc_done) begin
              issued_q <= 1'b0;
              step_q <= step_q + 3'd1;
              if (stepw[37]) begin
                rdata_q <= cyc_rdata;
                st_q <= S_IDLE;
                if (abort_q) begin
                  abort_q <= 1'b0;
                  mode_q <= M_READ;
                end else begin
                  case (cmd_q)
                    `FES_C_CHIP_ERASE, `FES_C_PROGRAM, `FES_C_SUSPEND, `FES_C_RESUME: st_q <= S_PA;
                    `FES_C_SECT_ERASE: mode_q <= M_ERS;
                    `FES_C_AUTOSEL: mode_q <= (mode_q == M_SUSP) ? M_SASEL : M_ASEL;
                    `FES_C_RESET: mode_q <= (mode_q == M_SASEL) ? M_SUSP : M_READ;
                    default: mode_q <= mode_q;
                  endcase
                  if (cmd_q == `FES_C_SUSPEND) scnt_q <= scnt_q + 11'h001;
                end
              end
            end
          end
          S_WAIT: begin
            if (tick) st_q <= S_PA;
          end
          S_PA, S_PB: begin
            if (!issued_q & !inflight_q) begin
              cyc_start <= 1'b1;
              issued_q <= 1'b1;
            end else if (issued_q & cyc_done) begin
              issued_q <= 1'b0;
              first_q <= cyc_rdata;
              st_q <= S_PB;
              if (st_q == S_PB) begin
                stat_q <= cyc_rdata;
                if (cmd_q == `FES_C_RESUME) begin
                  // one toggle check decides whether the erase is running again
                  st_q <= S_IDLE;
                  mode_q <= toggling ? M_ERS : M_READ;
                  gap_q <= GAP;
                end else if (toggling & cyc_rdata[`FES_B_TLIMIT]) begin
                  fail_q <= 1'b1;
                  abort_q <= 1'b1;
                  step_q <= 3'd0;
                  st_q <= S_STEP;
                end else if (toggling) begin
                  st_q <= S_WAIT;
                end else begin
                  st_q <= S_IDLE;
                  case (cmd_q)
                    `FES_C_SUSPEND: mode_q <= M_SUSP;
                    `FES_C_PROGRAM: mode_q <= (mode_q == M_SUSP) ? M_SUSP : M_READ;
                    default: begin
                      mode_q <= M_READ;
                      scnt_q <= 11'h000;
                    end
                  endcase
                end
              end
            end
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flash bus cycle engine and poll pacing
  fes_bus_cycle u_cyc (
    .clk         (clk),
    .rstn        (rstn),
    .start       (cyc_start),
    .wr          (~stepw[36] & (st_q == S_STEP)),
    .addr        ((st_q == S_STEP) ? stepw[35:16] : addr_q),
    .wdata       (stepw[15:0]),
    .done        (cyc_done),
    .rdata       (cyc_rdata),
    .flash_addr  (flash_addr),
    .flash_dq_o  (flash_dq_o),
    .flash_dq_oe (flash_dq_oe),
    .flash_dq_i  (flash_dq_i),
    .flash_ce_n  (flash_ce_n),
    .flash_oe_n  (flash_oe_n),
    .flash_we_n  (flash_we_n)
  );

  fes_tick u_tick (
    .clk  (clk),
    .rstn (rstn),
    .tick (tick)
  );

endmodule // fes_ctrl

//--- design/fes_defs.vh
// constants for the flash erase / suspend / auto-select host controller
// assumes a 100 MHz clk; all times are converted to cycles or 1 us ticks here
`ifndef FES_DEFS_VH
`define FES_DEFS_VH

// clock rate and flash bus cycle timing
`define FES_CLK_MHZ       100
`define FES_T_SETUP_NS    20
`define FES_T_PULSE_NS    70
`define FES_T_HOLD_NS     30
`define FES_SETUP_CYC     ((`FES_T_SETUP_NS * `FES_CLK_MHZ + 999) / 1000)
`define FES_PULSE_CYC     ((`FES_T_PULSE_NS * `FES_CLK_MHZ + 999) / 1000)
`define FES_HOLD_CYC      ((`FES_T_HOLD_NS * `FES_CLK_MHZ + 999) / 1000)

// poll tick, resume-to-suspend spacing and suspend count limit
`define FES_TICK_NS       1000
`define FES_TICK_CYC      (`FES_TICK_NS * `FES_CLK_MHZ / 1000)
`define FES_GAP_MS        4
`define FES_GAP_TICKS     (`FES_GAP_MS * 1000000 / `FES_TICK_NS)
`define FES_SUSP_MAX      1024

// register byte offsets
`define FES_REG_CMD       8'h00
`define FES_REG_ADDR      8'h04
`define FES_REG_WDATA     8'h08
`define FES_REG_STATUS    8'h0C
`define FES_REG_RDATA     8'h10
`define FES_REG_CTRL      8'h14
`define FES_REG_SCOUNT    8'h18

// controller command codes written to the command register
`define FES_C_CHIP_ERASE  4'h1
`define FES_C_SECT_ERASE  4'h2
`define FES_C_SUSPEND     4'h3
`define FES_C_RESUME      4'h4
`define FES_C_AUTOSEL     4'h5
`define FES_C_PROGRAM     4'h6
`define FES_C_RESET       4'h7
`define FES_C_READ        4'h8
`define FES_C_READ_MID    4'h9
`define FES_C_READ_DID    4'hA
`define FES_C_PROT_VFY    4'hB
`define FES_C_WAIT_ERASE  4'hC

// flash bus codes and unlock addresses
`define FES_UNLOCK_A1     20'h00555
`define FES_UNLOCK_A2     20'h002AA
`define FES_D_UNLOCK1     16'h00AA
`define FES_D_UNLOCK2     16'h0055
`define FES_D_CONFIG      16'h0080
`define FES_D_CHIP_ERASE  16'h0010
`define FES_D_SECT_ERASE  16'h0030
`define FES_D_SUSPEND     16'h00B0
`define FES_D_RESUME      16'h0030
`define FES_D_AUTOSEL     16'h0090
`define FES_D_PROGRAM     16'h00A0
`define FES_D_RESET       16'h00F0
`define FES_PROT_LOW      12'h002

// status bit positions in a flash status word
`define FES_B_POLL        7
`define FES_B_TOGGLE      6
`define FES_B_TLIMIT      5

`endif

//--- design/fes_tick.v
// one-cycle enable pulse every FES_TICK_CYC clocks
// assumes a free running clk; paces polling and the spacing timer
`timescale 1ns/1ps
`include "fes_defs.vh"

module fes_tick (
  input  wire clk,   // system clock
  input  wire rstn,  // async reset, active low
  output reg  tick   // one-cycle pulse
);

  localparam integer LAST_N = `FES_TICK_CYC - 1;
  localparam [7:0] LAST = LAST_N[7:0];
  reg [7:0] cnt_q;

  ////////////////////////////////////////////////////////////////////////
  // free running divider
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 8'h00;
      tick  <= 1'b0;
    end else begin
      tick  <= (cnt_q == LAST);
      cnt_q <= (cnt_q == LAST) ? 8'h00 : cnt_q + 8'h01;
    end
  end

endmodule // fes_tick

//--- design/fes_bus_cycle.v
// one asynchronous flash bus cycle, write or read, paced by counted phases
// assumes the flash data pins are sampled at the end of the read pulse
`timescale 1ns/1ps
`include "fes_defs.vh"

module fes_bus_cycle (
  input  wire        clk,        // system clock
  input  wire        rstn,       // async reset, active low
  input  wire        start,      // pulse: begin a cycle
  input  wire        wr,         // 1 write, 0 read
  input  wire [19:0] addr,       // word address
  input  wire [15:0] wdata,      // write data
  output reg         done,       // pulse: cycle finished
  output reg  [15:0] rdata,      // read data
  output reg  [19:0] flash_addr, // address pins
  output reg  [15:0] flash_dq_o, // data pins out
  output reg         flash_dq_oe,// data pins driven
  input  wire [15:0] flash_dq_i, // data pins in
  output reg         flash_ce_n, // chip enable
  output reg         flash_oe_n, // output enable
  output reg         flash_we_n  // write enable
);

  localparam [1:0] S_IDLE = 2'd0, S_SETUP = 2'd1, S_PULSE = 2'd2, S_HOLD = 2'd3;
  localparam integer N_SET = `FES_SETUP_CYC - 1, N_PUL = `FES_PULSE_CYC - 1, N_HLD = `FES_HOLD_CYC - 1;
  localparam [3:0] C_SET = N_SET[3:0], C_PUL = N_PUL[3:0], C_HLD = N_HLD[3:0];

  reg [1:0] st_q;
  reg [3:0] cnt_q;
  reg       wr_q;

  ////////////////////////////////////////////////////////////////////////
  // setup, strobe pulse, hold; ce stays low for the whole cycle
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= S_IDLE;
      cnt_q <= 4'h0;
      wr_q <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
      flash_addr <= 20'h00000;
      flash_dq_o <= 16'h0000;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
    end else begin
      done <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (start) begin
            st_q <= S_SETUP;
            cnt_q <= C_SET;
            wr_q <= wr;
            flash_addr <= addr;
            flash_dq_o <= wdata;
            flash_dq_oe <= wr;
            flash_ce_n <= 1'b0;
          end
        end
        S_SETUP: begin
          if (cnt_q == 4'h0) begin
            st_q <= S_PULSE;
            cnt_q <= C_PUL;
            flash_we_n <= ~wr_q;
            flash_oe_n <= wr_q;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        S_PULSE: begin
          if (cnt_q == 4'h0) begin
            st_q <= S_HOLD;
            cnt_q <= C_HLD;
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            if (!wr_q) begin
              rdata <= flash_dq_i;
            end
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        S_HOLD: begin
          if (cnt_q == 4'h0) begin
            st_q <= S_IDLE;
            flash_ce_n <= 1'b1;
            flash_dq_oe <= 1'b0;
            done <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

endmodule // fes_bus_cycle

//--- verification/fes_checker.sv
// checker on the controller pins: strobe shapes, control bits
// assumes a bind onto fes_ctrl, one clock domain
`timescale 1ns/1ps
module fes_checker (
  input logic        clk,           // clock
  input logic        rstn,          // reset
  input logic        psel,          // apb
  input logic        penable,       // apb
  input logic        pwrite,        // apb
  input logic [7:0]  paddr,         // apb
  input logic [31:0] pwdata,        // apb
  input logic [19:0] flash_addr,    // pin
  input logic [15:0] flash_dq_o,    // pin
  input logic        flash_dq_oe,   // pin
  input logic        flash_ce_n,    // pin
  input logic        flash_oe_n,    // pin
  input logic        flash_we_n,    // pin
  input logic        flash_reset_n, // pin
  input logic        id_hv_en       // pin
);
  // a control register write and its two bits
  wire ctl_wr = psel && penable && pwrite && paddr == 8'h14;
  wire rst_bit = pwdata[0];
  wire hv_bit = pwdata[1];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////
  AST_WE_SETUP: assert property ($fell(flash_we_n) |-> !$past(flash_ce_n) && flash_dq_oe)
    else $error("write strobe without enable or data");
  AST_WE_WIDTH: assert property ($fell(flash_we_n) |-> !flash_we_n[*7] ##1 flash_we_n)
    else $error("write pulse width wrong");
  AST_WE_STABLE: assert property (!flash_we_n && !$past(flash_we_n) |-> $stable(flash_addr) && $stable(flash_dq_o))
    else $error("address or data moved in write pulse");
  AST_CE_HOLD: assert property ($rose(flash_we_n) |-> !flash_ce_n[*3] ##1 flash_ce_n)
    else $error("write hold wrong");
  AST_OE_WIDTH: assert property ($fell(flash_oe_n) |-> !flash_oe_n[*7] ##1 flash_oe_n)
    else $error("read pulse width wrong");
  AST_NO_FIGHT: assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n && !flash_ce_n)
    else $error("read while driving");
  AST_HW_RESET: assert property (ctl_wr |=> flash_reset_n == !$past(rst_bit))
    else $error("reset pin not following control");
  AST_HV_SET: assert property (ctl_wr |=> id_hv_en == $past(hv_bit))
    else $error("hv pin not following control");
  AST_HV_HOLD: assert property (!ctl_wr |=> $stable(id_hv_en))
    else $error("hv pin moved on its own");
endmodule // fes_checker
bind fes_ctrl fes_checker fes_checker_i (.*);

//--- verification/fes_flash_model.sv
// behavioural flash: unlocks, erases, suspend, auto-select
// assumes the bench clock samples the strobes and paces its timers
`timescale 1ns/1ps
module fes_flash_model #(
  parameter int   ERASE_CYC = 3000, // embedded erase length
  parameter int   TOUT_CYC  = 5000, // 50 us window
  parameter int   SUSP_CYC  = 200,  // suspend latency
  parameter [7:0] MAKER_ID  = 8'h5A, // arbitrary value
  parameter [7:0] DEVICE_ID = 8'h3C  // arbitrary value
) (
  input  logic        clk,           // timer clock
  input  logic [19:0] flash_addr,    // address
  input  logic [15:0] flash_dq_o,    // host data
  input  logic        flash_dq_oe,   // host drives
  input  logic        flash_ce_n,    // enable
  input  logic        flash_oe_n,    // read strobe
  input  logic        flash_we_n,    // write strobe
  input  logic        flash_reset_n, // hw reset
  input  logic        id_hv_en,      // hv id
  input  logic        fail,          // erase overruns
  output logic [15:0] flash_dq_i,    // bus level
  output logic        ready_busy_n   // driven low while busy
);
  logic [2:0]  mode = 0, stp = 0;
  logic [7:0]  esec = 0;
  logic        tog = 0, we_q = 1, oe_q = 1;
  logic [15:0] last = 0;
  int          cnt = 0;
  wire [11:0] a = flash_addr[11:0];
  wire [7:0]  d = flash_dq_o[7:0];
  wire u1 = a == 12'h555 && d == 8'hAA;
  wire u2 = a == 12'h2AA && d == 8'h55;
  wire busy = mode == 2 || mode == 3 || mode == 4 || mode == 7;
  wire insec = mode == 2 || flash_addr[19:12] == esec;
  wire [15:0] idw = flash_addr[1:0] == 0 ? {8'h00, MAKER_ID} : flash_addr[1:0] == 1 ? {8'h00, DEVICE_ID}
                  : {15'h0, ^flash_addr[19:12]};
  wire [15:0] st = {8'h00, !busy, busy & tog, fail, 1'b0, mode != 3, tog & insec, 2'b00};
  wire [15:0] rd = (mode == 1 || mode == 6 || id_hv_en) ? idw : (busy || mode == 5 && insec) ? st
                 : 16'hFFFF;
  // released bus shows the inverse of its last value, never a kind guess
  assign flash_dq_i = flash_dq_oe ? flash_dq_o : (!flash_oe_n && !flash_ce_n) ? rd : ~last;
  assign ready_busy_n = !busy;
  ////////////////////////////////////////////////////////////
  // writes taken at the rise of the write strobe; timers below
  always @(posedge clk) begin
    we_q <= flash_we_n;
    oe_q <= flash_oe_n;
    if (!flash_oe_n) last <= rd;
    if (oe_q && !flash_oe_n) tog <= ~tog;
    if (!flash_reset_n) begin
      mode <= 0;
      stp <= 0;
    end else if (flash_we_n && !we_q && !flash_ce_n) begin
      if (busy) begin
        if (fail && d == 8'hF0) mode <= 0;
        else if (mode == 3 && d == 8'hB0) mode <= 5;
        else if (mode == 4 && d == 8'hB0) begin mode <= 7; cnt <= SUSP_CYC; end
        else if (mode == 3 && d == 8'h30) cnt <= TOUT_CYC;
        else if (mode == 3 && !u1 && !u2 && d != 8'h80) mode <= 0;
      end else if (mode == 1 || mode == 6) begin
        if (d == 8'hF0) mode <= mode == 6 ? 3'd5 : 3'd0;
      end else begin
        stp <= 0;
        if ((stp == 0 || stp == 3) && u1 || (stp == 1 || stp == 4) && u2 || stp == 2 && u1 ^ (a == 12'h555 && d == 8'h80))
          stp <= stp + 3'd1;
        if (stp == 2 && a == 12'h555 && d == 8'h90) mode <= mode == 5 ? 3'd6 : 3'd1;
        if (stp == 0 && mode == 5 && d == 8'h30) begin mode <= 4; cnt <= ERASE_CYC; end
        if (stp == 5 && mode == 0 && u1 ^ (a == 12'h555 && d == 8'h10)) begin mode <= 2; cnt <= ERASE_CYC; end
        if (stp == 5 && mode == 0 && d == 8'h30) begin mode <= 3; esec <= flash_addr[19:12]; cnt <= TOUT_CYC; end
      end
    end else if (cnt != 0) cnt <= cnt - 1;
    else if (mode == 3) begin mode <= 4; cnt <= ERASE_CYC; end
    else if (mode == 7) mode <= 5;
    else if ((mode == 2 || mode == 4) && !fail) mode <= 0;
  end
endmodule // fes_flash_model

//--- verification/test_flash_erase_suspend_autoselect.sv
// self-checking bench: controller, flash model, apb stimulus
// assumes design/ on the include path
`timescale 1ns/1ps
module test_flash_erase_suspend_autoselect;
  localparam [15:0] MID = 16'h005A, DID = 16'h003C; // arbitrary ids
  logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, fail = 0, er = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic [15:0] lf = 16'h003F;
  wire  [31:0] prdata;
  wire  [19:0] fa;
  wire  [15:0] dqo, dqi;
  wire         pready, pslverr, dqoe, ce_n, oe_n, we_n, frst_n, hv, rb_n;
  int          n_fail = 0, checks = 0, k;
  always #5 clk = ~clk;
  fes_ctrl fes_ctrl_i (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_addr(fa), .flash_dq_o(dqo),
    .flash_dq_oe(dqoe), .flash_dq_i(dqi), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .flash_reset_n(frst_n), .id_hv_en(hv), .ready_busy_n(rb_n));
  fes_flash_model #(.MAKER_ID(MID[7:0]), .DEVICE_ID(DID[7:0])) fes_flash_model_i (.clk(clk), .flash_addr(fa),
    .flash_dq_o(dqo), .flash_dq_oe(dqoe), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .flash_reset_n(frst_n), .id_hv_en(hv), .fail(fail), .flash_dq_i(dqi), .ready_busy_n(rb_n));
  ////////////////////////////////////////////////////////////
  function automatic [15:0] nxt(input [15:0] s);
    nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // ids by low address bits; parity of the sector marks protection
  function automatic [15:0] exp_id(input [19:0] x);
    exp_id = x[1:0] == 2'b00 ? MID : x[1:0] == 2'b01 ? DID : {15'h0, ^x[19:12]};
  endfunction
  task automatic apb(input [7:0] x, input w, input [31:0] v);
    @(posedge clk);
    psel <= 1; penable <= 0; paddr <= x; pwrite <= w; pwdata <= v;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic chk(input string nm, input [31:0] e, input [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // issue a command, then poll status until idle, bounded
  task automatic cmd(input [3:0] c);
    int i;
    apb(8'h00, 1, {28'h0, c});
    for (i = 0; i < 4000; i++) begin
      apb(8'h0C, 0, 0);
      if (rd[0] === 1'b0) break;
    end
    chk("busy", 0, {31'h0, rd[0]});
  endtask
  task automatic st(input [2:0] m);
    apb(8'h0C, 0, 0);
    chk("mode", {29'h0, m}, {29'h0, rd[5:3]});
  endtask
  task automatic rdat(input [15:0] e);
    apb(8'h10, 0, 0);
    chk("rdata", {16'h0, e}, {16'h0, rd[15:0]});
  endtask
  task automatic complete_run;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    n_fail++;
    $display("MISMATCH watchdog exp done got hang");
    complete_run;
  end
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1;
    apb(8'h04, 1, 0);
    apb(8'h14, 1, 2);
    cmd(4'h8);
    rdat(MID);
    apb(8'h14, 1, 0);
    cmd(4'h8);
    rdat(16'hFFFF);
    cmd(4'h5);
    st(1);
    for (k = 0; k < 3; k++) begin
      lf = nxt(lf);
      apb(8'h04, 1, {12'h0, lf[7:0], 12'h002});
      cmd(4'h9);
      rdat(exp_id({lf[7:0], 12'h000}));
      cmd(4'hA);
      rdat(exp_id({lf[7:0], 12'h001}));
      cmd(4'hB);
      rdat(exp_id({lf[7:0], 12'h002}));
    end
    cmd(4'h7);
    st(0);
    apb(8'h1C, 1, 5);
    chk("pslverr", 1, {31'h0, er});
    cmd(4'h4);
    chk("refused", 1, {31'h0, rd[1]});
    // hardware reset cuts a running chip erase short
    apb(8'h00, 1, 1);
    repeat (300) @(posedge clk);
    chk("erasing", 2, {29'h0, fes_flash_model_i.mode});
    apb(8'h14, 1, 1);
    apb(8'h14, 1, 0);
    chk("aborted", 0, {29'h0, fes_flash_model_i.mode});
    // one full chip erase, then one that overruns its time
    for (k = 0; k < 2; k++) begin
      fail <= k[0];
      apb(8'h00, 1, 1);
      cmd(4'hC);
      st(0);
      chk("fail", {31'h0, k[0]}, {31'h0, rd[2]});
      chk("poll", {31'h0, !k[0]}, {31'h0, rd[23]});
    end
    fail <= 0;
    lf = nxt(lf);
    apb(8'h04, 1, {12'h0, lf[7:0], 12'h000});
    cmd(4'h2);
    cmd(4'h3);
    st(3);
    cmd(4'h1);
    chk("refused", 1, {31'h0, rd[1]});
    cmd(4'h5);
    st(4);
    cmd(4'h7);
    st(3);
    cmd(4'h4);
    st(2);
    cmd(4'h3);
    chk("refused", 1, {31'h0, rd[1]});
    cmd(4'hC);
    st(0);
    complete_run;
  end
endmodule // test_flash_erase_suspend_autoselect
